/* File: src/pmt_target.sv */
// Management-bus target: serial bus engine with packet error checking,
// alert line, strapped address, working memory and power-good flag.
// Assumes fault, measurement, flash and strap inputs come from core logic on
// i_mclk; only the bus pins cross into this domain.
//
// Functional notes
// - Works at standard and fast bus rates.
// - Checks host check byte; appends check byte always.
// - Also serves hosts without check bytes.
// - Alert pulls shared line low, else releases.
// - Ignores alert response address; own address only.
// - Clear-faults releases alert and latched faults.
// - Flash copy only on store-all command.
// - Address is eight times high plus low digit.
// - Strap resistance decoded within one percent.
// - Bad strap resistance gives fallback address.
// - Reserved decoded addresses give fallback address.
// - Linear format only, exponent fixed.
// - Voltage words: unsigned mantissa, exponent minus twelve.
// - Other words: 11-bit mantissa, 5-bit exponent.
// - Power good high in range, low on faults.
// - Power-good thresholds set by on/off commands.
// - Clear-faults is send-byte code 03.
`timescale 1ns/1ps
`default_nettype none
`include "pmt_cfg.svh"

module pmt_target
   import pmt_pkg::*;
#(
   parameter int CLK_KHZ = `PMT_CLK_KHZ
)
(
   input wire logic i_mclk,
   input wire logic i_srst,
   input wire logic i_scl,
   input wire logic i_sda,
   output logic o_sda_out,
   output logic o_sda_oe_n,
   output logic o_alert_out,
   output logic o_alert_oe_n,
   input wire logic [`PMT_STRAP_W-1:0] i_address_digit_low_pin,
   input wire logic [`PMT_STRAP_W-1:0] i_address_digit_high_pin,
   input wire logic [15:0] i_vout_meas,
   input wire logic [10:0] i_iout_meas,
   input wire logic i_fault_ot,
   input wire logic i_fault_oc,
   input wire logic i_fault_reg,
   input wire logic i_power_running,
   input wire logic [15:0] i_flash_vout,
   input wire logic [15:0] i_flash_pg_on,
   input wire logic [15:0] i_flash_pg_off,
   output logic [15:0] o_vout_setpoint,
   output logic o_flash_store,
   output logic [15:0] o_flash_vout,
   output logic [15:0] o_flash_pg_on,
   output logic [15:0] o_flash_pg_off,
   output logic o_output_good_flag,
   output logic [6:0] o_bus_addr
);

   // Each bit needs several samples at the fast rate to find clean edges.
   if (CLK_KHZ < `PMT_SCL_FAST_KHZ * `PMT_MIN_SAMPLES)
   begin : g_chk
      $error("Core clock too slow to sample the fast bus rate.");
   end

   function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
      logic [7:0] x;
      x = c ^ b;
      for (int i = 0; i < 8; i++)
      begin
         x = x[7] ? ({x[6:0], 1'b0} ^ 8'h07) : {x[6:0], 1'b0};
      end
      return x;
   endfunction

   // =====================================================================
   // Pin synchronisers and bus conditions
   // =====================================================================
   logic scl_m_q, scl_s_q, scl_d_q, sda_m_q, sda_s_q, sda_d_q;
   logic scl_rise, scl_fall, start_det, stop_det;

   always_ff @(posedge i_mclk)
   begin
      if (i_srst)
      begin
         {scl_m_q, scl_s_q, scl_d_q} <= 3'h7;
         {sda_m_q, sda_s_q, sda_d_q} <= 3'h7;
      end
      else
      begin
         {scl_m_q, scl_s_q, scl_d_q} <= {i_scl, scl_m_q, scl_s_q};
         {sda_m_q, sda_s_q, sda_d_q} <= {i_sda, sda_m_q, sda_s_q};
      end
   end

   assign scl_rise = scl_s_q && !scl_d_q;
   assign scl_fall = !scl_s_q && scl_d_q;
   assign start_det = scl_s_q && scl_d_q && sda_d_q && !sda_s_q;
   assign stop_det = scl_s_q && scl_d_q && !sda_d_q && sda_s_q;

   // =====================================================================
   // Strapped address
   // =====================================================================
   pmt_strap_if lo_if();
   pmt_strap_if hi_if();
   logic [6:0] addr_raw, addr_res, addr_q;
   logic addr_rsv, init_q;

   assign lo_if.r_code = i_address_digit_low_pin;
   assign hi_if.r_code = i_address_digit_high_pin;

   pmt_strap_dec u_dec_lo (.s(lo_if));
   pmt_strap_dec u_dec_hi (.s(hi_if));

   assign addr_raw = 7'(`PMT_DIGIT_SCALE * hi_if.digit + lo_if.digit);
   assign addr_rsv = (addr_raw <= `PMT_ADDR_RSV_MAX) || (addr_raw == `PMT_ADDR_RSV_A) ||
                     (addr_raw == `PMT_ADDR_RSV_B) || (addr_raw == `PMT_ADDR_RSV_C) ||
                     (addr_raw == `PMT_ADDR_RSV_D);
   assign addr_res = (!lo_if.ok || !hi_if.ok || addr_rsv) ? `PMT_ADDR_FALLBACK : addr_raw;

   // The straps are caught once, at the first edge after reset release.
   always_ff @(posedge i_mclk)
   begin
      if (i_srst)
      begin
         init_q <= 1'b0;
         addr_q <= `PMT_ADDR_FALLBACK;
      end
      else if (!init_q)
      begin
         init_q <= 1'b1;
         addr_q <= addr_res;
      end
   end

   assign o_bus_addr = addr_q;

   // =====================================================================
   // Read data and write decode
   // =====================================================================
   pmt_state_t state_q;
   logic [3:0] cnt_q;
   logic [1:0] bidx_q, n_q, k_q, rd_len, wr_len;
   logic [7:0] sh_q, tx_sh_q, cmd_q, crc_q, txb, status;
   logic [15:0] wbuf_q, rd_word, vout_q, pg_on_q, pg_off_q;
   logic rd_q, drive_q, active_q, tx_data, wr_known, exec, good, pec_bad;
   logic [3:0] fault_q;

   always_comb
   begin
      status = 8'h00;
      status[`PMT_STB_CML] = fault_q[3];
      status[`PMT_STB_TEMP] = fault_q[0];
      status[`PMT_STB_IOUT_OC] = fault_q[1];
      status[`PMT_STB_OTHER] = fault_q[2];
   end

   always_comb
   begin
      rd_word = 16'hFFFF;
      rd_len = 2'h1;
      case (cmd_q)
         `PMT_CMD_VOUT_MODE: rd_word = {8'h00, `PMT_VOUT_MODE_VAL};
         `PMT_CMD_VOUT_COMMAND: begin rd_word = vout_q; rd_len = 2'h2; end
         `PMT_CMD_PG_ON: begin rd_word = pg_on_q; rd_len = 2'h2; end
         `PMT_CMD_PG_OFF: begin rd_word = pg_off_q; rd_len = 2'h2; end
         `PMT_CMD_STATUS_BYTE: rd_word = {8'h00, status};
         `PMT_CMD_READ_VOUT: begin rd_word = i_vout_meas; rd_len = 2'h2; end
         `PMT_CMD_READ_IOUT: begin rd_word = {`PMT_IOUT_EXP, i_iout_meas}; rd_len = 2'h2; end
         default: rd_word = 16'hFFFF;
      endcase
   end

   // Data bytes go out low byte first, then the check byte.
   assign tx_data = k_q < rd_len;
   assign txb = !tx_data ? crc_q : ((k_q == 2'h0) ? rd_word[7:0] : rd_word[15:8]);

   always_comb
   begin
      wr_known = 1'b1;
      wr_len = 2'h0;
      case (cmd_q)
         `PMT_CMD_CLEAR_FAULTS, `PMT_CMD_STORE_ALL, `PMT_CMD_RESTORE_ALL: wr_len = 2'h0;
         `PMT_CMD_VOUT_COMMAND, `PMT_CMD_PG_ON, `PMT_CMD_PG_OFF: wr_len = 2'h2;
         default: wr_known = 1'b0;
      endcase
   end

   // A write runs at the stop: bare length is accepted, length plus one must
   // carry a matching check byte, which leaves a zero remainder.
   assign exec = stop_det && active_q && !rd_q && (bidx_q == 2'h2);
   assign pec_bad = (n_q == wr_len + 2'h1) && (crc_q != 8'h00);
   assign good = wr_known && ((n_q == wr_len) || ((n_q == wr_len + 2'h1) && !pec_bad)) &&
                 !((cmd_q == `PMT_CMD_RESTORE_ALL) && i_power_running);

   // =====================================================================
   // Bus engine
   // =====================================================================
   always_ff @(posedge i_mclk)
   begin
      if (i_srst)
      begin
         state_q <= PMT_ST_IDLE;
         {cnt_q, bidx_q, n_q, k_q} <= 10'h000;
         {sh_q, tx_sh_q, cmd_q, crc_q} <= 32'h0000_0000;
         wbuf_q <= 16'h0000;
         {rd_q, drive_q, active_q} <= 3'h0;
      end
      else if (start_det)
      begin
         state_q <= PMT_ST_RX;
         {cnt_q, bidx_q, k_q} <= 8'h00;
         drive_q <= 1'b0;
         active_q <= 1'b1;
         if (!active_q)
         begin
            crc_q <= 8'h00;
         end
      end
      else if (stop_det)
      begin
         state_q <= PMT_ST_IDLE;
         drive_q <= 1'b0;
         active_q <= 1'b0;
      end
      else
      begin
         unique case (state_q)
            PMT_ST_IDLE:
            begin
               drive_q <= 1'b0;
            end
            PMT_ST_RX:
            begin
               if (scl_rise && (cnt_q != 4'h8))
               begin
                  sh_q <= {sh_q[6:0], sda_s_q};
                  cnt_q <= cnt_q + 4'h1;
               end
               else if (scl_fall && (cnt_q == 4'h8))
               begin
                  if ((bidx_q == 2'h0) && (sh_q[7:1] != addr_q))
                  begin
                     state_q <= PMT_ST_IDLE;
                  end
                  else
                  begin
                     drive_q <= 1'b1;
                     state_q <= PMT_ST_RX_ACK;
                     crc_q <= crc8(crc_q, sh_q);
                     if (bidx_q == 2'h0)
                     begin
                        rd_q <= sh_q[0];
                     end
                     else if (bidx_q == 2'h1)
                     begin
                        cmd_q <= sh_q;
                        n_q <= 2'h0;
                     end
                     else
                     begin
                        if (n_q == 2'h0)
                        begin
                           wbuf_q[7:0] <= sh_q;
                        end
                        else if (n_q == 2'h1)
                        begin
                           wbuf_q[15:8] <= sh_q;
                        end
                        n_q <= (n_q == 2'h3) ? n_q : n_q + 2'h1;
                     end
                  end
               end
            end
            PMT_ST_RX_ACK:
            begin
               if (scl_fall)
               begin
                  bidx_q <= (bidx_q == 2'h2) ? bidx_q : bidx_q + 2'h1;
                  if ((bidx_q == 2'h0) && rd_q)
                  begin
                     tx_sh_q <= {txb[6:0], 1'b0};
                     drive_q <= !txb[7];
                     crc_q <= tx_data ? crc8(crc_q, txb) : crc_q;
                     k_q <= 2'h1;
                     cnt_q <= 4'h1;
                     state_q <= PMT_ST_TX;
                  end
                  else
                  begin
                     drive_q <= 1'b0;
                     cnt_q <= 4'h0;
                     state_q <= PMT_ST_RX;
                  end
               end
            end
            PMT_ST_TX:
            begin
               if (scl_fall)
               begin
                  if (cnt_q == 4'h8)
                  begin
                     drive_q <= 1'b0;
                     state_q <= PMT_ST_TX_ACK;
                  end
                  else
                  begin
                     drive_q <= !tx_sh_q[7];
                     tx_sh_q <= {tx_sh_q[6:0], 1'b0};
                     cnt_q <= cnt_q + 4'h1;
                  end
               end
            end
            PMT_ST_TX_ACK:
            begin
               // A host without check bytes simply refuses the check byte.
               if (scl_rise && sda_s_q)
               begin
                  state_q <= PMT_ST_IDLE;
               end
               else if (scl_fall)
               begin
                  tx_sh_q <= {txb[6:0], 1'b0};
                  drive_q <= !txb[7];
                  crc_q <= tx_data ? crc8(crc_q, txb) : crc_q;
                  k_q <= (k_q == 2'h3) ? k_q : k_q + 2'h1;
                  cnt_q <= 4'h1;
                  state_q <= PMT_ST_TX;
               end
            end
         endcase
      end
   end

   assign o_sda_out = 1'b0;
   assign o_sda_oe_n = !drive_q;

   // =====================================================================
   // Working memory and flash copy
   // =====================================================================
   always_ff @(posedge i_mclk)
   begin
      if (i_srst)
      begin
         vout_q <= `PMT_RST_VOUT;
         pg_on_q <= `PMT_RST_PG_ON;
         pg_off_q <= `PMT_RST_PG_OFF;
         o_flash_store <= 1'b0;
         o_flash_vout <= `PMT_RST_VOUT;
         o_flash_pg_on <= `PMT_RST_PG_ON;
         o_flash_pg_off <= `PMT_RST_PG_OFF;
      end
      else
      begin
         o_flash_store <= 1'b0;
         if (exec && good)
         begin
            case (cmd_q)
               `PMT_CMD_VOUT_COMMAND: vout_q <= wbuf_q;
               `PMT_CMD_PG_ON: pg_on_q <= wbuf_q;
               `PMT_CMD_PG_OFF: pg_off_q <= wbuf_q;
               `PMT_CMD_STORE_ALL:
               begin
                  o_flash_store <= 1'b1;
                  o_flash_vout <= vout_q;
                  o_flash_pg_on <= pg_on_q;
                  o_flash_pg_off <= pg_off_q;
               end
               `PMT_CMD_RESTORE_ALL:
               begin
                  vout_q <= i_flash_vout;
                  pg_on_q <= i_flash_pg_on;
                  pg_off_q <= i_flash_pg_off;
               end
               default: vout_q <= vout_q;
            endcase
         end
      end
   end

   assign o_vout_setpoint = vout_q;

   // =====================================================================
   // Faults, alert and power good
   // =====================================================================
   // A new fault in the clearing cycle survives the clear.
   always_ff @(posedge i_mclk)
   begin
      if (i_srst)
      begin
         fault_q <= 4'h0;
      end
      else
      begin
         fault_q <= ((exec && good && (cmd_q == `PMT_CMD_CLEAR_FAULTS)) ? 4'h0 : fault_q) |
                    {exec && !good, i_fault_reg, i_fault_oc, i_fault_ot};
      end
   end

   assign o_alert_out = 1'b0;
   assign o_alert_oe_n = !(|fault_q);

   always_ff @(posedge i_mclk)
   begin
      if (i_srst)
      begin
         o_output_good_flag <= 1'b0;
      end
      else if (i_fault_ot || i_fault_oc || i_fault_reg || (i_vout_meas < pg_off_q))
      begin
         o_output_good_flag <= 1'b0;
      end
      else if (i_vout_meas >= pg_on_q)
      begin
         o_output_good_flag <= 1'b1;
      end
   end

   // =====================================================================
   // Checks
   // =====================================================================
   property p_alert_on_fault;
      @(posedge i_mclk) disable iff (i_srst) (i_fault_ot || i_fault_oc) |=> !o_alert_oe_n;
   endproperty
   a_alert_on_fault: assert property (p_alert_on_fault) else $error("Alert not raised on fault.");

   property p_clear_releases;
      @(posedge i_mclk) disable iff (i_srst)
         (exec && good && cmd_q == `PMT_CMD_CLEAR_FAULTS && !i_fault_ot && !i_fault_oc && !i_fault_reg)
         |=> o_alert_oe_n && (status == 8'h00);
   endproperty
   a_clear_releases: assert property (p_clear_releases) else $error("Clear did not release alert.");

   property p_addr_only_own;
      @(posedge i_mclk) disable iff (i_srst)
         (state_q == PMT_ST_RX_ACK && bidx_q == 2'h0) |-> (sh_q[7:1] == addr_q) && (addr_q != `PMT_ADDR_ARA);
   endproperty
   a_addr_only_own: assert property (p_addr_only_own) else $error("Acknowledged a foreign address.");

   property p_addr_compose;
      @(posedge i_mclk) disable iff (i_srst)
         $rose(init_q) && !addr_rsv && lo_if.ok && hi_if.ok |-> addr_q == {1'b0, $past(hi_if.digit), $past(lo_if.digit)};
   endproperty
   a_addr_compose: assert property (p_addr_compose) else $error("Address not formed from digits.");

   property p_addr_fallback;
      @(posedge i_mclk) disable iff (i_srst)
         $rose(init_q) && $past(addr_rsv || !lo_if.ok || !hi_if.ok) |-> addr_q == `PMT_ADDR_FALLBACK;
   endproperty
   a_addr_fallback: assert property (p_addr_fallback) else $error("Bad strap did not give fallback.");

   property p_pec_reject;
      @(posedge i_mclk) disable iff (i_srst) (exec && pec_bad) |=> $stable(vout_q) && fault_q[3];
   endproperty
   a_pec_reject: assert property (p_pec_reject) else $error("Bad check byte accepted.");

   property p_store_cause;
      @(posedge i_mclk) disable iff (i_srst)
         !$stable(o_flash_vout) |-> $past(exec && good && cmd_q == `PMT_CMD_STORE_ALL);
   endproperty
   a_store_cause: assert property (p_store_cause) else $error("Flash copy changed without store.");

   property p_pg_fault;
      @(posedge i_mclk) disable iff (i_srst) (i_fault_ot || i_fault_oc || i_fault_reg) |=> !o_output_good_flag;
   endproperty
   a_pg_fault: assert property (p_pg_fault) else $error("Power good held during fault.");

   property p_drive_on_low_clock;
      @(posedge i_mclk) disable iff (i_srst) $fell(o_sda_oe_n) |-> $past(scl_fall);
   endproperty
   a_drive_on_low_clock: assert property (p_drive_on_low_clock) else $error("Data driven outside low clock.");

endmodule

`default_nettype wire

/* File: src/pmt_cfg.svh */
// Constants for the management-bus target: command codes, reset values,
// address straps and bus timing. Included by every design file except the type package.
`ifndef PMT_CFG_SVH
`define PMT_CFG_SVH

// Command codes.
`define PMT_CMD_CLEAR_FAULTS 8'h03
`define PMT_CMD_STORE_ALL 8'h11
`define PMT_CMD_RESTORE_ALL 8'h12
`define PMT_CMD_VOUT_MODE 8'h20
`define PMT_CMD_VOUT_COMMAND 8'h21
`define PMT_CMD_PG_ON 8'h5E
`define PMT_CMD_PG_OFF 8'h5F
`define PMT_CMD_STATUS_BYTE 8'h78
`define PMT_CMD_READ_VOUT 8'h8B
`define PMT_CMD_READ_IOUT 8'h8C

// Data format: linear output voltage with exponent -12, current exponent -4.
`define PMT_VOUT_MODE_VAL 8'h14
`define PMT_IOUT_EXP 5'h1C

// Working-memory reset values (output voltage units of 2^-12 V).
`define PMT_RST_VOUT 16'hC000
`define PMT_RST_PG_ON 16'hB000
`define PMT_RST_PG_OFF 16'hA800

// Status byte bit positions.
`define PMT_STB_OTHER 0
`define PMT_STB_CML 1
`define PMT_STB_TEMP 2
`define PMT_STB_IOUT_OC 4

// Addressing.
`define PMT_ADDR_FALLBACK 7'h7F
`define PMT_ADDR_ARA 7'h0C
`define PMT_ADDR_RSV_MAX 7'h0C
`define PMT_ADDR_RSV_A 7'h28
`define PMT_ADDR_RSV_B 7'h2C
`define PMT_ADDR_RSV_C 7'h2D
`define PMT_ADDR_RSV_D 7'h37
`define PMT_DIGIT_SCALE 7'h08

// Strap resistance in units of 10 ohm, nominal per octal digit, 1 % window.
`define PMT_STRAP_W 15
`define PMT_STRAP_NOM0 15'h03E8
`define PMT_STRAP_NOM1 15'h0604
`define PMT_STRAP_NOM2 15'h0942
`define PMT_STRAP_NOM3 15'h0E42
`define PMT_STRAP_NOM4 15'h1572
`define PMT_STRAP_NOM5 15'h2102
`define PMT_STRAP_NOM6 15'h32C8
`define PMT_STRAP_NOM7 15'h4E20
`define PMT_STRAP_TOL_DIV 100

// Bus rates and the sampling margin needed at the fastest one.
`define PMT_CLK_KHZ 25000
`define PMT_SCL_STD_KHZ 100
`define PMT_SCL_FAST_KHZ 400
`define PMT_MIN_SAMPLES 16

`endif

/* File: src/pmt_pkg.sv */
// Types shared by the management-bus target modules.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package pmt_pkg;

   typedef enum logic [2:0] {
      PMT_ST_IDLE = 3'b000,
      PMT_ST_RX = 3'b001,
      PMT_ST_RX_ACK = 3'b010,
      PMT_ST_TX = 3'b011,
      PMT_ST_TX_ACK = 3'b100
   } pmt_state_t;

   typedef logic [2:0] pmt_digit_t;

endpackage

`default_nettype wire

/* File: src/pmt_strap_if.sv */
// Carrier between the target top and one strap decoder.
// Assumes the strap resistance code is produced in the core clock domain.
`timescale 1ns/1ps
`default_nettype none
`include "pmt_cfg.svh"

interface pmt_strap_if;
   logic [`PMT_STRAP_W-1:0] r_code;
   logic [2:0] digit;
   logic ok;
   modport dec (input r_code, output digit, output ok);
   modport user (output r_code, input digit, input ok);
endinterface

`default_nettype wire

/* File: src/pmt_strap_dec.sv */
// Decoder from one strap resistance code to an octal address digit.
// Assumes the code is a settled measurement in units of 10 ohm.
`timescale 1ns/1ps
`default_nettype none
`include "pmt_cfg.svh"

module pmt_strap_dec
   import pmt_pkg::*;
#(
   parameter int R_W = `PMT_STRAP_W
)
(
   pmt_strap_if.dec s
);

   localparam logic [R_W-1:0] NOM [8] = '{`PMT_STRAP_NOM0, `PMT_STRAP_NOM1, `PMT_STRAP_NOM2,
      `PMT_STRAP_NOM3, `PMT_STRAP_NOM4, `PMT_STRAP_NOM5, `PMT_STRAP_NOM6, `PMT_STRAP_NOM7};

   if (R_W < `PMT_STRAP_W)
   begin : g_chk
      $error("Strap code too narrow for the highest nominal value.");
   end

   logic [7:0] hit;

   // =====================================================================
   // Window compare
   // =====================================================================
   // Windows are far apart, so at most one of them can match.
   for (genvar g = 0; g < 8; g++)
   begin : g_win
      localparam logic [R_W-1:0] LO = R_W'(NOM[g] - NOM[g] / `PMT_STRAP_TOL_DIV);
      localparam logic [R_W-1:0] HI = R_W'(NOM[g] + NOM[g] / `PMT_STRAP_TOL_DIV);
      assign hit[g] = (s.r_code >= LO) && (s.r_code <= HI);
   end

   always_comb
   begin
      s.digit = 3'h0;
      for (int i = 0; i < 8; i++)
      begin
         if (hit[i])
         begin
            s.digit = 3'(i);
         end
      end
   end

   assign s.ok = |hit;

endmodule

`default_nettype wire

/* File: testbench/pmt_host.sv */
// Host controller model driving the bus clock and data open drain.
// Assumes the bench resolves the data wire and feeds it back on i_sda.
`timescale 1ns/1ps
`default_nettype none
module pmt_host (
   output logic o_scl,
   output logic o_sda,
   input wire logic i_sda
);
   initial
   begin
      o_scl = 1'b1;
      o_sda = 1'b1;
   end
   // One bit at a 320 ns bus period; the clock stands high between frames.
   task automatic bit_io(input logic b, output logic r);
      o_sda = b;
      #80 o_scl = 1'b1;
      #160 r = i_sda;
      o_scl = 1'b0;
      #80;
   endtask
   task automatic start();
      o_sda = 1'b1;
      #80 o_scl = 1'b1;
      #80 o_sda = 1'b0;
      #80 o_scl = 1'b0;
      #80;
   endtask
   task automatic stop();
      o_sda = 1'b0;
      #80 o_scl = 1'b1;
      #80 o_sda = 1'b1;
      #160;
   endtask
   task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q, output logic k);
      for (int i = 7; i >= 0; i--)
         bit_io(d[i], q[i]);
      bit_io(a, k);
   endtask
endmodule
`default_nettype wire

/* File: testbench/testbench.sv */
// Self-checking bench for the management-bus target.
// Assumes pmt_host drives the bus; the target's address is strapped to 0x13.
`timescale 1ns/1ps
`default_nettype none
`include "pmt_cfg.svh"
module testbench;
   localparam logic [6:0] ADDR = 7'h13;
   logic mclk, srst, scl, h_sda, sda, oe_n, al_n, good, sda_o, run, fstore;
   logic [14:0] lo_s, hi_s;
   logic [15:0] vout, setp, fvout, fpgon;
   logic [2:0] f;
   logic [6:0] addr;
   int errors = 0;
   int check_count = 0;
   int stores = 0;
   assign sda = oe_n ? h_sda : sda_o;
   pmt_host host (.o_scl(scl), .o_sda(h_sda), .i_sda(sda));
   pmt_target dut (.i_mclk(mclk), .i_srst(srst), .i_scl(scl), .i_sda(sda), .o_sda_out(sda_o),
      .o_sda_oe_n(oe_n), .o_alert_out(), .o_alert_oe_n(al_n), .i_address_digit_low_pin(lo_s),
      .i_address_digit_high_pin(hi_s), .i_vout_meas(vout), .i_iout_meas(11'h123), .i_fault_ot(f[2]),
      .i_fault_oc(f[1]), .i_fault_reg(f[0]), .i_power_running(run), .i_flash_vout(16'h1111),
      .i_flash_pg_on(16'h2222), .i_flash_pg_off(16'h3333), .o_vout_setpoint(setp), .o_flash_store(fstore),
      .o_flash_vout(fvout), .o_flash_pg_on(fpgon), .o_flash_pg_off(), .o_output_good_flag(good),
      .o_bus_addr(addr));
   initial
   begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   // The store pulse stands one cycle, so it is counted between rising edges.
   always @(negedge mclk)
      if (fstore)
         stores++;
   // ================================
   // Helpers
   function automatic logic [7:0] crc(input logic [7:0] c, input logic [7:0] d);
      c = c ^ d;
      for (int i = 0; i < 8; i++)
         c = c[7] ? {c[6:0], 1'b0} ^ 8'h07 : {c[6:0], 1'b0};
      return c;
   endfunction
   task automatic chk(input logic [15:0] s, input logic [15:0] e);
      check_count++;
      if (s !== e)
      begin
         errors++;
         $display("[ERR] %0t seen %h exp %h", $time, s, e);
      end
   endtask
   task automatic give_verdict();
      $display("errors %0d checks %0d", errors, check_count);
      if (errors == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic rst(input logic [14:0] lo, input logic [14:0] hi, input logic [6:0] e);
      @(negedge mclk);
      lo_s = lo;
      hi_s = hi;
      srst = 1'b1;
      repeat (3) @(negedge mclk);
      srst = 1'b0;
      repeat (4) @(negedge mclk);
      chk(16'(addr), 16'(e));
   endtask
   // Pec: 0 none, 1 correct, 2 corrupted.
   task automatic wr(input logic [7:0] cmd, input int n, input logic [15:0] d, input logic [1:0] pec);
      logic [7:0] q, c, b [4];
      logic k;
      b = '{{ADDR, 1'b0}, cmd, d[7:0], d[15:8]};
      c = 8'h00;
      host.start();
      for (int i = 0; i < n + 2; i++)
      begin
         host.xfer(b[i], 1'b1, q, k);
         chk(16'(k), 16'h0000);
         c = crc(c, b[i]);
      end
      if (pec != 2'b00)
         host.xfer(c ^ {7'h00, pec[1]}, 1'b1, q, k);
      host.stop();
      repeat (4) @(negedge mclk);
   endtask
   task automatic rd(input logic [7:0] cmd, input int n, input logic [15:0] e);
      logic [7:0] q, c;
      logic [15:0] v;
      logic k;
      host.start();
      host.xfer({ADDR, 1'b0}, 1'b1, q, k);
      host.xfer(cmd, 1'b1, q, k);
      host.start();
      host.xfer({ADDR, 1'b1}, 1'b1, q, k);
      c = crc(crc(crc(8'h00, {ADDR, 1'b0}), cmd), {ADDR, 1'b1});
      v = 16'h0000;
      for (int i = 0; i < n; i++)
      begin
         host.xfer(8'hFF, 1'b0, q, k);
         v[8*i+:8] = q;
         c = crc(c, q);
      end
      host.xfer(8'hFF, 1'b1, q, k);
      host.stop();
      chk(v, e);
      chk(16'(q), 16'(c));
   endtask
   task automatic ara_probe();
      logic [7:0] q;
      logic k;
      host.start();
      host.xfer({`PMT_ADDR_ARA, 1'b1}, 1'b1, q, k);
      host.stop();
      chk(16'(k), 16'h0001);
   endtask
   // ================================
   // Main sequence
   initial
   begin
      srst = 1'b1;
      f = 3'b000;
      vout = 16'hC000;
      run = 1'b1;
      rst(15'h0E42, 15'h0942, ADDR);
      rst(15'h0E67, 15'h0942, `PMT_ADDR_FALLBACK);
      rst(15'h2102, 15'h2102, `PMT_ADDR_FALLBACK);
      rst(15'h0E66, 15'h0942, ADDR);
      chk(16'(good), 16'h0001);
      wr(`PMT_CMD_VOUT_COMMAND, 2, 16'hB800, 2'b01);
      chk(setp, 16'hB800);
      wr(`PMT_CMD_VOUT_COMMAND, 2, 16'hB400, 2'b10);
      chk(setp, 16'hB800);
      chk(16'(al_n), 16'h0000);
      rd(`PMT_CMD_STATUS_BYTE, 1, 16'h0002);
      wr(`PMT_CMD_CLEAR_FAULTS, 0, 16'h0000, 2'b01);
      chk(16'(al_n), 16'h0001);
      wr(`PMT_CMD_VOUT_COMMAND, 2, 16'hB400, 2'b00);
      chk(setp, 16'hB400);
      chk(fvout, 16'hC000);
      wr(`PMT_CMD_STORE_ALL, 0, 16'h0000, 2'b01);
      chk(fvout, 16'hB400);
      chk(fpgon, 16'hB000);
      chk(16'(stores), 16'h0001);
      rd(`PMT_CMD_VOUT_MODE, 1, 16'h0014);
      rd(`PMT_CMD_READ_VOUT, 2, 16'hC000);
      rd(`PMT_CMD_READ_IOUT, 2, {5'h1C, 11'h123});
      @(negedge mclk);
      f = 3'b111;
      repeat (3) @(negedge mclk);
      chk(16'(al_n), 16'h0000);
      chk(16'(good), 16'h0000);
      rd(`PMT_CMD_STATUS_BYTE, 1, 16'h0015);
      ara_probe();
      f = 3'b000;
      wr(`PMT_CMD_CLEAR_FAULTS, 0, 16'h0000, 2'b01);
      chk(16'(al_n), 16'h0001);
      chk(16'(good), 16'h0001);
      wr(`PMT_CMD_VOUT_MODE, 1, 16'h0010, 2'b00);
      chk(16'(al_n), 16'h0000);
      wr(`PMT_CMD_RESTORE_ALL, 0, 16'h0000, 2'b00);
      chk(setp, 16'hB400);
      run = 1'b0;
      wr(`PMT_CMD_RESTORE_ALL, 0, 16'h0000, 2'b00);
      chk(setp, 16'h1111);
      wr(`PMT_CMD_CLEAR_FAULTS, 0, 16'h0000, 2'b00);
      chk(16'(al_n), 16'h0001);
      rd(`PMT_CMD_VOUT_COMMAND, 2, 16'h1111);
      wr(`PMT_CMD_PG_OFF, 2, 16'hC800, 2'b01);
      chk(16'(good), 16'h0000);
      rd(`PMT_CMD_PG_OFF, 2, 16'hC800);
      wr(`PMT_CMD_PG_ON, 2, 16'hD000, 2'b01);
      wr(`PMT_CMD_PG_OFF, 2, 16'hA000, 2'b01);
      chk(16'(good), 16'h0000);
      give_verdict();
   end
   initial
   begin
      #2000000;
      errors++;
      give_verdict();
   end
endmodule
`default_nettype wire
